// ### rtl/wswc_map.svh
// Constants of the wait/stop wake-up controller: offsets, fields, resets, counts.
// Assumes an 8-bit register port and a single 25 MHz core clock.
//
// What this block does
// - Cleared global enable blocks all but non-maskable
// - Route each enabled event to its source
// - Light sleep halts core, keeps all state
// - Light sleep keeps oscillator and peripherals clocked
// - Light sleep interrupt wake has no delay
// - Light sleep reset exit does full reset
// - Deep sleep stops oscillator, waits interrupt/reset
// - Deep sleep interrupt wake waits oscillator settle
// - Deep sleep pin reset does full reset
// - Active watchdog turns deep into light sleep
// - Wake never changes the clock source selection
// - From main program: service then next instruction
// - From non-maskable routine: resume, stay there
// - From maskable routine, maskable wake: continue routine
// - From maskable routine, non-maskable wake: service first
// - Global enable cleared: only reset ends sleep
// - Pending enabled request skips the sleep instruction
// - Global enable is option register bit 4
// - Sample requests at each instruction end
`ifndef WSWC_MAP_SVH
`define WSWC_MAP_SVH

`define WSWC_ADDR_W 8
`define WSWC_DATA_W 8

`define WSWC_OFS_IOR 8'hc8
`define WSWC_OFS_EVT_EN 8'he0
`define WSWC_OFS_STATUS 8'he1

`define WSWC_IOR_LES 6
`define WSWC_IOR_ESB 5
`define WSWC_IOR_GEN 4
`define WSWC_IOR_RESET 8'h00

`define WSWC_EN_TIMER 0
`define WSWC_EN_ADC 1
`define WSWC_EN_SUPPLY 2
`define WSWC_EN_LFOSC 3
`define WSWC_EN_CLKSEL 4
`define WSWC_EVT_EN_RESET 8'h00

`define WSWC_STAB_CYCLES 256

`endif

// ### rtl/wswc_pkg.sv
// Types shared by the wait/stop wake-up controller and its leaf modules.
// Assumes the constant header is compiled alongside.
package wswc_pkg;

	typedef enum logic [1:0] {
		WSWC_RUN = 2'b00,
		WSWC_LIGHT = 2'b01,
		WSWC_DEEP = 2'b10,
		WSWC_STAB = 2'b11
	} wswc_sleep_t;

	typedef enum logic [1:0] {
		WSWC_MODE_MAIN = 2'b00,
		WSWC_MODE_IRQ = 2'b01,
		WSWC_MODE_NMI = 2'b10
	} wswc_core_mode_t;

	typedef struct packed {
		logic nmi_n;
		logic supply_monitor_irq_flag;
		logic spi_irq_n;
		logic port_irq_n;
		logic timer_zero_flag;
		logic lowfreq_osc_event_flag;
		logic adc_eoc;
	} wswc_events_t;

	typedef struct packed {
		logic instr_end;
		logic light_cmd;
		logic deep_cmd;
		logic [4:0] irq_ack;
		wswc_core_mode_t mode;
	} wswc_core_req_t;

	typedef struct packed {
		logic halt;
		logic irq_take;
		logic [2:0] irq_src;
		logic resume;
		logic resume_service;
		logic [2:0] resume_src;
		logic sleep_skip;
	} wswc_core_ctl_t;

endpackage

// ### rtl/wswc_irq_route.sv
// Maps peripheral and pin events onto the five interrupt sources.
// Assumes event lines are synchronous to clk; ack pulses come from the core.
`timescale 1ns/1ps
`include "wswc_map.svh"
module wswc_irq_route import wswc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Events and configuration
	input wswc_events_t ev,
	input wire logic level_src1,
	input wire logic rising_src2,
	input wire logic [7:0] evt_en,
	input wire logic [4:0] irq_ack,
	// Raw requests, before global gating
	output logic [4:0] req
);

	typedef struct packed {
		logic [2:0] lat;
		logic nmi_n;
		logic spi_n;
		logic port_n;
	} wswc_route_st_t;

	wswc_route_st_t s_q, s_d;
	logic ev0, ev1, ev2;

	always_comb begin
		s_d = s_q;
		ev0 = (s_q.nmi_n & ~ev.nmi_n)
			| (ev.supply_monitor_irq_flag & evt_en[`WSWC_EN_SUPPLY]);
		ev1 = s_q.spi_n & ~ev.spi_irq_n;
		ev2 = rising_src2 ? (~s_q.port_n & ev.port_irq_n) : (s_q.port_n & ~ev.port_irq_n);
		// Set wins over the core's acknowledge
		s_d.lat[0] = ev0 | (s_q.lat[0] & ~irq_ack[0]);
		s_d.lat[1] = ~level_src1 & (ev1 | (s_q.lat[1] & ~irq_ack[1]));
		s_d.lat[2] = ev2 | (s_q.lat[2] & ~irq_ack[2]);
		s_d.nmi_n = ev.nmi_n;
		s_d.spi_n = ev.spi_irq_n;
		s_d.port_n = ev.port_irq_n;
		req[0] = s_q.lat[0];
		req[1] = level_src1 ? ~ev.spi_irq_n : s_q.lat[1];
		req[2] = s_q.lat[2];
		req[3] = (ev.timer_zero_flag & evt_en[`WSWC_EN_TIMER])
			| (ev.lowfreq_osc_event_flag & evt_en[`WSWC_EN_LFOSC]);
		req[4] = ev.adc_eoc & evt_en[`WSWC_EN_ADC];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{lat: 3'h0, nmi_n: 1'b1, spi_n: 1'b1, port_n: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

endmodule

// ### rtl/wswc_stab_timer.sv
// Oscillator settle counter run after a deep-sleep wake.
// Assumes start is a one-cycle pulse and no restart while busy.
`timescale 1ns/1ps
module wswc_stab_timer import wswc_pkg::*; #(
	parameter int unsigned STAB_CYCLES = 256
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic start,
	output logic done
);

	typedef struct packed {
		logic busy;
		logic [15:0] cnt;
	} wswc_stab_st_t;

	wswc_stab_st_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		done = s_q.busy && s_q.cnt == 16'h0001;
		if (start) begin
			s_d.busy = 1'b1;
			s_d.cnt = 16'(STAB_CYCLES);
		end else if (s_q.busy) begin
			s_d.cnt = s_q.cnt - 16'h0001;
			if (done) begin
				s_d.busy = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

// ### rtl/wswc_top.sv
// Wait/stop wake-up controller: sleep states, wake-up and resume decisions,
// interrupt option register and event routing toward the core.
// Assumes the core obeys halt and reports instruction ends and mode.
`timescale 1ns/1ps
`include "wswc_map.svh"
module wswc_top import wswc_pkg::*; #(
	parameter int unsigned STAB_CYCLES = `WSWC_STAB_CYCLES
) (
	// Clock and resets
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic wdog_reset,
	input wire logic wdog_active,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Events
	input wswc_events_t ev,
	// Core side
	input wswc_core_req_t core_req,
	output wswc_core_ctl_t core_ctl,
	output logic core_reset_req,
	// Clocking
	output logic osc_stop,
	output logic periph_clk_en,
	output logic clk_src_sel
);

	typedef struct packed {
		wswc_sleep_t st;
		logic [7:0] interrupt_option_reg;
		logic [7:0] evt_en;
		logic [7:0] rdata;
		wswc_core_ctl_t ctl;
		logic rst_req;
		wswc_core_mode_t entry_mode;
	} wswc_top_st_t;

	wswc_top_st_t s_q, s_d;
	logic [1:0] rsync_q;
	logic rst_n;
	logic [4:0] req;
	logic [4:0] req_gated;
	logic [4:0] req_core;
	logic gen;
	logic wake;
	logic stab_start;
	logic stab_done;

	// Highest priority pending source; source 0 first, 4 last
	function automatic logic [2:0] prio(input logic [4:0] r);
		logic [2:0] p;
		p = 3'h0;
		for (int i = 4; i >= 0; i--) begin
			if (r[i]) begin
				p = 3'(i);
			end
		end
		return p;
	endfunction

	// Release of the reset is synchronised; assertion stays asynchronous
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rsync_q <= 2'b00;
		end else begin
			rsync_q <= {rsync_q[0], 1'b1};
		end
	end
	assign rst_n = rsync_q[1];

	wswc_irq_route u_route (
		.clk(ref_clk),
		.rst_n(rst_n),
		.ev(ev),
		.level_src1(s_q.interrupt_option_reg[`WSWC_IOR_LES]),
		.rising_src2(s_q.interrupt_option_reg[`WSWC_IOR_ESB]),
		.evt_en(s_q.evt_en),
		// A watchdog reset also empties the edge latches, as a pin reset would
		.irq_ack(core_req.irq_ack | {5{wdog_reset}}),
		.req(req)
	);

	wswc_stab_timer #(
		.STAB_CYCLES(STAB_CYCLES)
	) u_stab (
		.clk(ref_clk),
		.rst_n(rst_n),
		.start(stab_start),
		.done(stab_done)
	);

	always_comb begin
		gen = s_q.interrupt_option_reg[`WSWC_IOR_GEN];
		// Non-maskable source is never gated for service
		req_gated = {req[4:1] & {4{gen}}, req[0]};
		// Wake needs the global enable, even for the non-maskable source
		wake = gen & (|req);
		// What the core may take now depends on its mode
		case (core_req.mode)
			WSWC_MODE_MAIN: req_core = req_gated;
			WSWC_MODE_IRQ: req_core = {4'h0, req[0]};
			WSWC_MODE_NMI: req_core = 5'h00;
			default: req_core = 5'h00;
		endcase
	end

	always_comb begin
		s_d = s_q;
		stab_start = 1'b0;
		s_d.ctl.irq_take = 1'b0;
		s_d.ctl.resume = 1'b0;
		s_d.ctl.resume_service = 1'b0;
		s_d.ctl.sleep_skip = 1'b0;
		s_d.rst_req = wdog_reset;
		s_d.rdata = 8'h00;

		// Register port; the option register is write-only and reads zero
		if (reg_wr) begin
			case (reg_addr)
				`WSWC_OFS_IOR: s_d.interrupt_option_reg = reg_wdata;
				`WSWC_OFS_EVT_EN: s_d.evt_en = reg_wdata;
				default: s_d.interrupt_option_reg = s_q.interrupt_option_reg;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`WSWC_OFS_EVT_EN: s_d.rdata = s_q.evt_en;
				`WSWC_OFS_STATUS: s_d.rdata = {1'b0, s_q.st, req};
				default: s_d.rdata = 8'h00;
			endcase
		end

		case (s_q.st)
			WSWC_RUN: begin
				s_d.ctl.halt = 1'b0;
				if (core_req.light_cmd || core_req.deep_cmd) begin
					s_d.entry_mode = core_req.mode;
					if (|req_gated) begin
						// Pending enabled request: instruction acts as a no-op
						s_d.ctl.sleep_skip = 1'b1;
					end else if (core_req.deep_cmd && !wdog_active) begin
						s_d.st = WSWC_DEEP;
						s_d.ctl.halt = 1'b1;
					end else begin
						// Watchdog would starve in deep sleep, so it is downgraded
						s_d.st = WSWC_LIGHT;
						s_d.ctl.halt = 1'b1;
					end
				end else if (core_req.instr_end && (|req_core)) begin
					s_d.ctl.irq_take = 1'b1;
					s_d.ctl.irq_src = prio(req_core);
				end
			end
			WSWC_LIGHT: begin
				if (wake) begin
					// Oscillator never stopped, resume on the next edge
					s_d.st = WSWC_RUN;
					s_d.ctl.halt = 1'b0;
					s_d.ctl.resume = 1'b1;
				end
			end
			WSWC_DEEP: begin
				if (wake) begin
					s_d.st = WSWC_STAB;
					stab_start = 1'b1;
				end
			end
			WSWC_STAB: begin
				if (stab_done) begin
					s_d.st = WSWC_RUN;
					s_d.ctl.halt = 1'b0;
					s_d.ctl.resume = 1'b1;
				end
			end
			default: begin
				s_d.st = WSWC_RUN;
				s_d.ctl.halt = 1'b0;
			end
		endcase

		// Resume decision, captured as the wake is seen
		if ((s_q.st == WSWC_LIGHT || s_q.st == WSWC_DEEP) && wake) begin
			case (s_q.entry_mode)
				WSWC_MODE_MAIN: begin
					s_d.ctl.resume_service = 1'b1;
					s_d.ctl.resume_src = prio(req_gated);
				end
				WSWC_MODE_IRQ: begin
					// Only the non-maskable source may preempt the routine
					s_d.ctl.resume_service = req[0];
					s_d.ctl.resume_src = 3'h0;
				end
				WSWC_MODE_NMI: begin
					s_d.ctl.resume_service = 1'b0;
					s_d.ctl.resume_src = 3'h0;
				end
				default: begin
					s_d.ctl.resume_service = 1'b0;
					s_d.ctl.resume_src = 3'h0;
				end
			endcase
		end
		// Service flag of a deep wake, set as the wake is seen, is held through the settle delay
		if (s_q.st == WSWC_STAB) begin
			s_d.ctl.resume_service = stab_done & s_q.ctl.resume_service;
			if (!stab_done) begin
				s_d.ctl.resume_service = s_q.ctl.resume_service;
			end
		end

		// Watchdog reset aborts any sleep into a full reset
		if (wdog_reset) begin
			s_d.st = WSWC_RUN;
			s_d.ctl.halt = 1'b0;
			s_d.interrupt_option_reg = `WSWC_IOR_RESET;
			s_d.evt_en = `WSWC_EVT_EN_RESET;
			s_d.entry_mode = WSWC_MODE_MAIN;
			s_d.ctl = '0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			// Pin reset from any state lands here: the full sequence
			s_q.st <= WSWC_RUN;
			s_q.interrupt_option_reg <= `WSWC_IOR_RESET;
			s_q.evt_en <= `WSWC_EVT_EN_RESET;
			s_q.rdata <= 8'h00;
			s_q.ctl <= '0;
			s_q.rst_req <= 1'b1;
			s_q.entry_mode <= WSWC_MODE_MAIN;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign core_reset_req = s_q.rst_req;
	// Core halt only; peripherals keep their clock except in deep sleep, and RAM keeps its contents
	assign core_ctl = s_q.ctl;
	// Oscillator runs in light sleep and while settling
	assign osc_stop = (s_q.st == WSWC_DEEP);
	assign periph_clk_en = (s_q.st != WSWC_DEEP);
	// Selection comes from software only; the wake path never writes it
	assign clk_src_sel = s_q.evt_en[`WSWC_EN_CLKSEL];

endmodule

// ### verification/wswc_monitor.sv
// Port checker for the wake-up controller.
// Assumes it is bound onto wswc_top and shares its reset.
`timescale 1ns/1ps
module wswc_monitor import wswc_pkg::*; #(
	parameter int unsigned STAB_CYCLES = 256
) (
	// Watched top ports
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic wdog_reset,
	input wire logic wdog_active,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wswc_core_req_t core_req,
	input wswc_core_ctl_t core_ctl,
	input wire logic core_reset_req,
	input wire logic osc_stop,
	input wire logic periph_clk_en,
	input wire logic clk_src_sel
);
	localparam int SB = STAB_CYCLES + 2;
	// Shadow of the global enable, since the option register reads back 0
	logic gen_q;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			gen_q <= 1'b0;
		end else if (wdog_reset) begin
			gen_q <= 1'b0;
		end else if (reg_wr && reg_addr == 8'hc8) begin
			gen_q <= reg_wdata[4];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_clk_gate;
		osc_stop == !periph_clk_en;
	endproperty
	a_clk_gate: assert property (p_clk_gate) else $error("clock gate mismatch");
	property p_wdog_light;
		core_req.deep_cmd && wdog_active && !wdog_reset |=> !osc_stop;
	endproperty
	a_wdog_light: assert property (p_wdog_light) else $error("deep with watchdog");
	property p_stab;
		$fell(osc_stop) && !core_reset_req |-> core_ctl.halt[*3] ##[1:SB] core_ctl.resume;
	endproperty
	a_stab: assert property (p_stab) else $error("settle delay wrong");
	property p_src_hold;
		!(reg_wr && reg_addr == 8'he0) && !wdog_reset |=> $stable(clk_src_sel);
	endproperty
	a_src_hold: assert property (p_src_hold) else $error("clock source moved");
	property p_gen_off;
		core_ctl.halt && !gen_q && !wdog_reset |=> core_ctl.halt;
	endproperty
	a_gen_off: assert property (p_gen_off) else $error("woke with enable off");
	property p_take;
		core_ctl.irq_take |-> $past(core_req.instr_end) && ($past(gen_q) || core_ctl.irq_src == 3'h0);
	endproperty
	a_take: assert property (p_take) else $error("bad interrupt take");
	property p_nmi_mode;
		core_ctl.resume && core_req.mode == WSWC_MODE_NMI |-> !core_ctl.resume_service;
	endproperty
	a_nmi_mode: assert property (p_nmi_mode) else $error("service in nmi mode");
	property p_irq_mode;
		core_ctl.resume && core_req.mode == WSWC_MODE_IRQ && core_ctl.resume_service
			|-> core_ctl.resume_src == 3'h0;
	endproperty
	a_irq_mode: assert property (p_irq_mode) else $error("service in irq mode");
	c_resume: cover property (core_ctl.resume && core_ctl.resume_service);
	c_deep: cover property ($fell(osc_stop));
	c_skip: cover property (core_ctl.sleep_skip);
endmodule

bind wswc_top wswc_monitor #(.STAB_CYCLES(STAB_CYCLES)) mon_u (.ref_clk, .resetn, .wdog_reset,
	.wdog_active, .reg_addr, .reg_wdata, .reg_wr, .core_req, .core_ctl, .core_reset_req,
	.osc_stop, .periph_clk_en, .clk_src_sel);

// ### verification/wswc_core_model.sv
// Behavioural core: ends instructions, issues sleep commands, starts routines.
// Assumes go pulses from the bench last one cycle.
`timescale 1ns/1ps
module wswc_core_model import wswc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bench control
	input wire logic go_light,
	input wire logic go_deep,
	input wswc_core_mode_t mode,
	// Controller side
	input wswc_core_ctl_t ctl,
	output wswc_core_req_t req
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req <= '0;
		end else begin
			// A halted core ends no instruction
			req.instr_end <= !ctl.halt && !req.instr_end && !go_light && !go_deep;
			req.light_cmd <= go_light;
			req.deep_cmd <= go_deep;
			req.mode <= mode;
			req.irq_ack <= '0;
			if (ctl.irq_take) begin
				req.irq_ack[ctl.irq_src] <= 1'b1;
			end
			if (ctl.resume && ctl.resume_service) begin
				req.irq_ack[ctl.resume_src] <= 1'b1;
			end
		end
	end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the wake-up controller.
// Assumes the core model answers on the core side.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
	$display("[FAIL] %0t compare mismatch", $time); end end
module tb_top import wswc_pkg::*;;
	typedef struct packed {wswc_events_t e; logic [7:0] en; logic [7:0] st;} wswc_row_t;
	localparam int SC = 4;
	localparam wswc_events_t IDLE = 7'h58;
	localparam wswc_events_t TZ = 7'h5c;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic wdog_reset = 1'b0;
	logic wdog_active = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic go_l = 1'b0;
	logic go_d = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [7:0] d;
	logic [2:0] h;
	logic core_reset_req, osc_stop, periph_clk_en, clk_src_sel;
	wswc_core_mode_t md = WSWC_MODE_MAIN;
	wswc_events_t ev = IDLE;
	wswc_core_req_t core_req;
	wswc_core_ctl_t core_ctl;
	wswc_core_ctl_t r;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int n;
	// Supply, serial, timer, low-freq osc, converter, then a gated timer
	wswc_row_t rows [6] = '{'{7'h78, 8'h04, 8'h01}, '{7'h48, 8'h00, 8'h02},
		'{7'h5c, 8'h01, 8'h08}, '{7'h5a, 8'h08, 8'h08}, '{7'h59, 8'h02, 8'h10},
		'{7'h5c, 8'h0e, 8'h00}};
	wswc_top #(.STAB_CYCLES(SC)) dut_u (.ref_clk, .resetn, .wdog_reset, .wdog_active, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ev, .core_req, .core_ctl, .core_reset_req,
		.osc_stop, .periph_clk_en, .clk_src_sel);
	wswc_core_model core_u (.clk(ref_clk), .rst_n(resetn), .go_light(go_l), .go_deep(go_d),
		.mode(md), .ctl(core_ctl), .req(core_req));
	always #20 ref_clk = !ref_clk;
	task close_out;
		$display("errors=%0d tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			close_out();
		end
	end
	task wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask
	task wake(input logic dp, input wswc_core_mode_t m, input wswc_events_t e);
		@(posedge ref_clk);
		md <= m;
		go_l <= !dp;
		go_d <= dp;
		@(posedge ref_clk);
		go_l <= 1'b0;
		go_d <= 1'b0;
		repeat (3) @(negedge ref_clk);
		h = {core_ctl.halt, osc_stop, periph_clk_en};
		ev <= e;
		for (n = 0; n < 40 && core_ctl.resume !== 1'b1; n++) @(negedge ref_clk);
		r = core_ctl;
		// Sources quiet again before the next sleep
		ev <= IDLE;
		repeat (4) @(posedge ref_clk);
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(8'hc8); `CHK(d, 8'h00)
		rd(8'hff); `CHK(d, 8'h00)
		wr(8'hc8, 8'h40);
		foreach (rows[i]) begin
			wr(8'he0, rows[i].en);
			ev <= rows[i].e;
			repeat (2) @(posedge ref_clk);
			rd(8'he1); `CHK(d, rows[i].st)
			ev <= IDLE;
		end
		wr(8'he0, 8'h11);
		wr(8'hc8, 8'h10);
		ev <= TZ;
		@(posedge ref_clk);
		go_l <= 1'b1;
		@(posedge ref_clk);
		go_l <= 1'b0;
		for (n = 0; n < 6 && core_ctl.sleep_skip !== 1'b1; n++) @(negedge ref_clk);
		`CHK({n < 6, core_ctl.halt}, 2'b10)
		ev <= IDLE;
		wake(1'b0, WSWC_MODE_MAIN, TZ); `CHK(h, 3'b101)
		`CHK(n <= 2, 1'b1)
		`CHK({r.resume_service, r.resume_src}, 4'b1011)
		wake(1'b1, WSWC_MODE_MAIN, TZ); `CHK(h, 3'b110)
		`CHK(n >= SC && n <= SC + 4, 1'b1)
		wdog_active <= 1'b1;
		wake(1'b1, WSWC_MODE_MAIN, TZ); `CHK(h, 3'b101)
		wdog_active <= 1'b0;
		wake(1'b0, WSWC_MODE_NMI, TZ); `CHK(r.resume_service, 1'b0)
		wake(1'b0, WSWC_MODE_IRQ, TZ); `CHK(r.resume_service, 1'b0)
		wake(1'b0, WSWC_MODE_IRQ, 7'h18); `CHK({r.resume_service, r.resume_src}, 4'b1000)
		`CHK(clk_src_sel, 1'b1)
		wr(8'hc8, 8'h00);
		ev <= 7'h50;
		repeat (2) @(posedge ref_clk);
		rd(8'he1); `CHK(d, 8'h04)
		wake(1'b0, WSWC_MODE_MAIN, TZ); `CHK(n, 40)
		@(posedge ref_clk);
		wdog_reset <= 1'b1;
		@(posedge ref_clk);
		wdog_reset <= 1'b0;
		@(negedge ref_clk);
		`CHK({core_reset_req, core_ctl.halt}, 2'b10)
		wr(8'hc8, 8'h10);
		wake(1'b1, WSWC_MODE_MAIN, IDLE); `CHK(osc_stop, 1'b1)
		resetn <= 1'b0;
		@(negedge ref_clk);
		`CHK({osc_stop, core_reset_req, core_ctl}, 13'h0800)
		close_out();
	end
endmodule
